/* design/rtc_tempcomp_dst_control.sv */
// Functional notes
// [R1] Five low trim bits of compensation control load at power-up; writes never change them.
// [R2] Bit 7 enables sensing; with main supply, correct frequency every sixty seconds.
// [R3] Bits 6 and 5 choose compensation behaviour while running on battery.
// [R4] Host should read-modify-write control, keeping the five trim bits unchanged.
// [R5] Each control write with sense enable set starts a compensation cycle.
// [R6] Trim offset and curvature coefficient registers are read-only; writes ignored.
// [R7] Time advances at forward setting, goes back at reverse setting, every year.
// [R8] Forward month register holds enable bit plus BCD month.
// [R9] Week/day registers hold week, weekday, and select bit replacing date matching.
// [R10] Hour and month settings are plain BCD; hour has no 24-hour flag.
// [R11] Week value seven means last matching weekday of the month.
// [R12] Forward-done flag sets on forward change; clears on reverse, reset, or disable.
// [R13] Daylight-saving enable is the top bit of the forward month register.
// [R14] One-byte word address follows slave byte; pointer increments per data byte.
`timescale 1ns/1ps
`default_nettype none

module rtc_tempcomp_dst_control
	import rtc_tcdst_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR           = DEV_ADDR_DEFAULT,
	parameter int         CORR_PERIOD        = CORR_PERIOD_CYCLES,
	parameter int         TEMP_W             = 10,
	parameter int         ANALOG_TRIM_W      = 6,
	parameter int         DIGITAL_TRIM_W     = 3
) (
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	input  wire logic                      scl_in,
	input  wire logic                      sda_in,
	output logic                           sda_out,
	output logic                           sda_oe,
	input  wire logic [7:0]                fuse_trim_offset,
	input  wire logic [7:0]                fuse_curve_coeff,
	input  wire logic [SLOPE_TRIM_W-1:0]   fuse_slope_trim,
	input  wire logic                      vdd_present,
	input  wire logic                      on_battery,
	input  wire logic [TEMP_W-1:0]         temp_code,
	input  wire logic [ANALOG_TRIM_W-1:0]  corr_analog,
	input  wire logic [DIGITAL_TRIM_W-1:0] corr_digital,
	input  wire logic                      hour_tick,
	input  wire logic [7:0]                cal_month,
	input  wire logic [7:0]                cal_date,
	input  wire logic [7:0]                cal_hour,
	input  wire logic [2:0]                cal_weekday,
	input  wire logic [7:0]                cal_month_len,
	output logic                           comp_cycle_start,
	output logic [1:0]                     comp_batt_mode,
	output logic [ANALOG_TRIM_W-1:0]       analog_freq_trim,
	output logic [DIGITAL_TRIM_W-1:0]      digital_freq_trim,
	output logic                           dst_advance,
	output logic                           dst_retard,
	output logic                           daylight_forward_done
);

	logic [1:0]                rst_sync;
	logic                      rst_n;
	logic                      fuse_loaded_reg;
	logic [7:0]                trim_offset_reg;
	logic [7:0]                curve_coeff_reg;
	logic [SLOPE_TRIM_W-1:0]   slope_trim_reg;
	logic                      temp_sense_enable_reg;
	logic [1:0]                batt_mode_reg;
	logic [7:0]                fwd_month_reg;
	logic [7:0]                fwd_weekday_reg;
	logic [7:0]                fwd_date_reg;
	logic [7:0]                fwd_hour_reg;
	logic [7:0]                rev_month_reg;
	logic [7:0]                rev_weekday_reg;
	logic [7:0]                rev_date_reg;
	logic [7:0]                rev_hour_reg;
	logic [29:0]               period_cnt_reg;
	logic                      period_due;
	logic                      write_start;
	logic                      comp_start_next;
	logic                      temp_valid_reg;
	logic [TEMP_W-1:0]         last_temp_reg;
	logic                      daylight_saving_enable;
	logic                      fwd_hit;
	logic                      rev_hit;
	logic [7:0]                ptr;
	logic                      wr_en;
	logic [7:0]                wr_data;
	logic [7:0]                rd_data;
	logic                      ser_sda_oe;
	logic                      periodic_allowed;

	// Read decode for every mapped register
	function automatic logic [7:0] reg_read(input logic [7:0] a);
		unique case (a)
			ADDR_TRIM_OFFSET: reg_read = trim_offset_reg;
			ADDR_CURVE_COEFF: reg_read = curve_coeff_reg;
			ADDR_SLOPE_CTRL:  reg_read = {temp_sense_enable_reg, batt_mode_reg, slope_trim_reg};
			ADDR_FWD_MONTH:   reg_read = fwd_month_reg;
			ADDR_FWD_WEEKDAY: reg_read = fwd_weekday_reg;
			ADDR_FWD_DATE:    reg_read = fwd_date_reg;
			ADDR_FWD_HOUR:    reg_read = fwd_hour_reg;
			ADDR_REV_MONTH:   reg_read = rev_month_reg;
			ADDR_REV_WEEKDAY: reg_read = rev_weekday_reg;
			ADDR_REV_DATE:    reg_read = rev_date_reg;
			ADDR_REV_HOUR:    reg_read = rev_hour_reg;
			default:          reg_read = BYTE_ZERO;
		endcase
	endfunction

	// Reset release through two flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Serial register access
	reg_serial_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_slave (
		.clk     (clk),
		.rst_n   (rst_n),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.sda_oe  (ser_sda_oe),
		.ptr     (ptr),
		.rd_data (rd_data),
		.wr_en   (wr_en),
		.wr_data (wr_data)
	);
	assign rd_data = reg_read(ptr);

	// Open-drain data pin: only ever pulls low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_out <= 1'b0;
			sda_oe  <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			sda_oe  <= ser_sda_oe;
		end
	end

	// Factory values captured once after reset release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fuse_loaded_reg <= 1'b0;
			trim_offset_reg <= BYTE_ZERO;
			curve_coeff_reg <= BYTE_ZERO;
			slope_trim_reg  <= '0;
		end else if (!fuse_loaded_reg) begin
			fuse_loaded_reg <= 1'b1;
			trim_offset_reg <= fuse_trim_offset; // [R6]
			curve_coeff_reg <= fuse_curve_coeff; // [R6]
			slope_trim_reg  <= fuse_slope_trim; // [R1]
		end
	end

	// Compensation control bits; trim bits and read-only registers ignore writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			temp_sense_enable_reg <= 1'b0;
			batt_mode_reg         <= BATT_MODE_RESET;
		end else if (wr_en && ptr == ADDR_SLOPE_CTRL) begin
			temp_sense_enable_reg <= wr_data[TSE_BIT]; // [R2]
			batt_mode_reg         <= wr_data[BATT_MODE_HI:BATT_MODE_LO]; // [R3]
		end
	end

	// Daylight-saving settings
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fwd_month_reg   <= BYTE_ZERO;
			fwd_weekday_reg <= BYTE_ZERO;
			fwd_date_reg    <= BYTE_ZERO;
			fwd_hour_reg    <= BYTE_ZERO;
			rev_month_reg   <= BYTE_ZERO;
			rev_weekday_reg <= BYTE_ZERO;
			rev_date_reg    <= BYTE_ZERO;
			rev_hour_reg    <= BYTE_ZERO;
		end else if (wr_en) begin
			unique case (ptr)
				ADDR_FWD_MONTH:   fwd_month_reg   <= wr_data; // [R8]
				ADDR_FWD_WEEKDAY: fwd_weekday_reg <= wr_data; // [R9]
				ADDR_FWD_DATE:    fwd_date_reg    <= wr_data;
				ADDR_FWD_HOUR:    fwd_hour_reg    <= wr_data; // [R10]
				ADDR_REV_MONTH:   rev_month_reg   <= wr_data;
				ADDR_REV_WEEKDAY: rev_weekday_reg <= wr_data; // [R9]
				ADDR_REV_DATE:    rev_date_reg    <= wr_data;
				ADDR_REV_HOUR:    rev_hour_reg    <= wr_data; // [R10]
				default: ;
			endcase
		end
	end

	// Periodic correction runs on main supply, or on battery if a mode is chosen
	assign periodic_allowed = temp_sense_enable_reg &&
		(vdd_present || (on_battery && batt_mode_reg != BATT_MODE_RESET)); // [R3]

	// Sixty-second interval counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			period_cnt_reg <= '0;
		end else if (!periodic_allowed || period_due) begin
			period_cnt_reg <= '0;
		end else begin
			period_cnt_reg <= 30'(period_cnt_reg + 30'h1);
		end
	end
	assign period_due = periodic_allowed && (period_cnt_reg == 30'(CORR_PERIOD - 1)); // [R2]

	// A control write with sensing enabled also starts a cycle
	assign write_start     = wr_en && (ptr == ADDR_SLOPE_CTRL) && wr_data[TSE_BIT]; // [R5]
	assign comp_start_next = write_start || period_due;

	// Start pulse and battery mode out
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			comp_cycle_start <= 1'b0;
			comp_batt_mode   <= BATT_MODE_RESET;
		end else begin
			comp_cycle_start <= comp_start_next;
			comp_batt_mode   <= batt_mode_reg;
		end
	end

	// New correction only when the temperature moved since the last conversion
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			temp_valid_reg    <= 1'b0;
			last_temp_reg     <= '0;
			analog_freq_trim  <= '0;
			digital_freq_trim <= '0;
		end else if (comp_start_next && (!temp_valid_reg || temp_code != last_temp_reg)) begin
			temp_valid_reg    <= 1'b1;
			last_temp_reg     <= temp_code;
			analog_freq_trim  <= corr_analog; // [R5]
			digital_freq_trim <= corr_digital; // [R5]
		end
	end

	// Enable bit sits at the top of the forward month register
	assign daylight_saving_enable = fwd_month_reg[DAYLIGHT_SAVING_ENABLE_BIT]; // [R13]

	// Forward and reverse date/time matchers
	dst_matcher u_fwd_match (
		.cfg_month     (fwd_month_reg),
		.cfg_weekday   (fwd_weekday_reg),
		.cfg_date      (fwd_date_reg),
		.cfg_hour      (fwd_hour_reg),
		.cal_month     (cal_month),
		.cal_date      (cal_date),
		.cal_hour      (cal_hour),
		.cal_weekday   (cal_weekday),
		.cal_month_len (cal_month_len),
		.hit           (fwd_hit)
	);

	dst_matcher u_rev_match (
		.cfg_month     (rev_month_reg),
		.cfg_weekday   (rev_weekday_reg),
		.cfg_date      (rev_date_reg),
		.cfg_hour      (rev_hour_reg),
		.cal_month     (cal_month),
		.cal_date      (cal_date),
		.cal_hour      (cal_hour),
		.cal_weekday   (cal_weekday),
		.cal_month_len (cal_month_len),
		.hit           (rev_hit)
	);

	// Yearly adjust pulses; the flag stops a repeated hour from re-firing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dst_advance <= 1'b0;
			dst_retard  <= 1'b0;
		end else begin
			dst_advance <= hour_tick && daylight_saving_enable && fwd_hit &&
				!daylight_forward_done; // [R7]
			dst_retard  <= hour_tick && daylight_saving_enable && rev_hit &&
				daylight_forward_done; // [R7]
		end
	end

	// Forward-done status
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			daylight_forward_done <= 1'b0; // [R12]
		end else if (!daylight_saving_enable || dst_retard) begin
			daylight_forward_done <= 1'b0; // [R12]
		end else if (dst_advance) begin
			daylight_forward_done <= 1'b1; // [R12]
		end
	end

endmodule // rtc_tempcomp_dst_control

`default_nettype wire

/* design/rtc_tcdst_pkg.sv */
package rtc_tcdst_pkg;

	// Register map
	localparam logic [7:0] ADDR_TRIM_OFFSET = 8'h0B;
	localparam logic [7:0] ADDR_CURVE_COEFF = 8'h0C;
	localparam logic [7:0] ADDR_SLOPE_CTRL  = 8'h0D;
	localparam logic [7:0] ADDR_FWD_MONTH   = 8'h15;
	localparam logic [7:0] ADDR_FWD_WEEKDAY = 8'h16;
	localparam logic [7:0] ADDR_FWD_DATE    = 8'h17;
	localparam logic [7:0] ADDR_FWD_HOUR    = 8'h18;
	localparam logic [7:0] ADDR_REV_MONTH   = 8'h19;
	localparam logic [7:0] ADDR_REV_WEEKDAY = 8'h1A;
	localparam logic [7:0] ADDR_REV_DATE    = 8'h1B;
	localparam logic [7:0] ADDR_REV_HOUR    = 8'h1C;
	localparam logic [7:0] ADDR_PTR_FIRST   = 8'h00;
	localparam logic [7:0] ADDR_PTR_LAST    = 8'h2F;

	// Default serial slave address
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h6F;

	// Compensation control fields
	localparam int TSE_BIT      = 7;
	localparam int BATT_MODE_HI = 6;
	localparam int BATT_MODE_LO = 5;
	localparam int SLOPE_TRIM_W = 5;

	// Daylight-saving fields
	localparam int DAYLIGHT_SAVING_ENABLE_BIT    = 7;
	localparam int MONTH_HI    = 4;
	localparam int WD_SEL_BIT  = 6;
	localparam int WEEK_HI     = 5;
	localparam int WEEK_LO     = 3;
	localparam int DAY_HI      = 2;
	localparam int DAY_LO      = 0;
	localparam logic [2:0] WEEK_LAST = 3'h7;
	localparam logic [6:0] DAYS_PER_WEEK = 7'h07;

	// Reset values
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [1:0] BATT_MODE_RESET = 2'h0;

	// Timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int CORR_PERIOD_S = 60;
	localparam int CORR_PERIOD_CYCLES = CORR_PERIOD_S * CLK_HZ;

endpackage

/* design/dst_matcher.sv */
`timescale 1ns/1ps
`default_nettype none

module dst_matcher
	import rtc_tcdst_pkg::*;
(
	input  wire logic [7:0] cfg_month,
	input  wire logic [7:0] cfg_weekday,
	input  wire logic [7:0] cfg_date,
	input  wire logic [7:0] cfg_hour,
	input  wire logic [7:0] cal_month,
	input  wire logic [7:0] cal_date,
	input  wire logic [7:0] cal_hour,
	input  wire logic [2:0] cal_weekday,
	input  wire logic [7:0] cal_month_len,
	output logic            hit
);

	// Two-digit BCD to binary
	function automatic logic [6:0] bcd2bin(input logic [7:0] b);
		logic [6:0] tens;
		logic [6:0] ones;
		tens = {3'h0, b[7:4]};
		ones = {3'h0, b[3:0]};
		bcd2bin = 7'((tens << 3) + (tens << 1) + ones);
	endfunction

	logic [6:0] date_bin;
	logic [6:0] len_bin;
	logic [2:0] week_of_month;
	logic       in_last_week;
	logic       month_ok;
	logic       hour_ok;
	logic       day_ok;

	// Week of month and last-week detection
	assign date_bin      = bcd2bin(cal_date);
	assign len_bin       = bcd2bin(cal_month_len);
	assign week_of_month = 3'(((date_bin - 7'h01) / DAYS_PER_WEEK) + 7'h01);
	assign in_last_week  = (7'(date_bin + DAYS_PER_WEEK) > len_bin); // [R11]

	// Month ignores the enable bit; hour is plain 24-hour BCD
	assign month_ok = ({3'h0, cfg_month[MONTH_HI:0]} == cal_month); // [R10]
	assign hour_ok  = (cfg_hour == cal_hour); // [R10]

	// Week/day matching replaces date matching when selected
	always_comb begin
		if (cfg_weekday[WD_SEL_BIT]) begin // [R9]
			day_ok = (cfg_weekday[DAY_HI:DAY_LO] == cal_weekday) &&
				((cfg_weekday[WEEK_HI:WEEK_LO] == WEEK_LAST) ? in_last_week // [R11]
				: (cfg_weekday[WEEK_HI:WEEK_LO] == week_of_month));
		end else begin
			day_ok = (cfg_date == cal_date);
		end
	end

	assign hit = month_ok && hour_ok && day_ok; // [R7]

endmodule // dst_matcher

`default_nettype wire

/* design/reg_serial_slave.sv */
`timescale 1ns/1ps
`default_nettype none

module reg_serial_slave
	import rtc_tcdst_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_oe,
	output logic [7:0]      ptr,
	input  wire logic [7:0] rd_data,
	output logic            wr_en,
	output logic [7:0]      wr_data
);

	typedef enum {ST_IDLE, ST_DEV, ST_DEV_ACK, ST_WORD, ST_WORD_ACK,
		ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK} ser_state_t;

	// Pointer advance with rollover
	function automatic logic [7:0] ptr_step(input logic [7:0] p);
		ptr_step = (p == ADDR_PTR_LAST) ? ADDR_PTR_FIRST : 8'(p + 8'h01);
	endfunction

	ser_state_t state_reg;
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic       scl_prev;
	logic       sda_prev;
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt;
	logic       rw_reg;
	logic       nack_reg;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_cond;
	logic       stop_cond;

	// Two-stage synchronisers, then edge history
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_prev <= scl_sync[1];
			sda_prev <= sda_sync[1];
		end
	end

	assign scl_rise   = scl_sync[1] && !scl_prev;
	assign scl_fall   = !scl_sync[1] && scl_prev;
	assign start_cond = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
	assign stop_cond  = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];

	// Byte framing, acknowledge and pointer handling
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			shift_reg <= BYTE_ZERO;
			bit_cnt   <= 4'h0;
			rw_reg    <= 1'b0;
			nack_reg  <= 1'b0;
			sda_oe    <= 1'b0;
			ptr       <= ADDR_PTR_FIRST;
			wr_en     <= 1'b0;
			wr_data   <= BYTE_ZERO;
		end else begin
			wr_en <= 1'b0;
			if (start_cond) begin
				state_reg <= ST_DEV;
				bit_cnt   <= 4'h0;
				sda_oe    <= 1'b0;
			end else if (stop_cond) begin
				state_reg <= ST_IDLE;
				sda_oe    <= 1'b0;
			end else if (scl_rise) begin
				if (state_reg == ST_DEV || state_reg == ST_WORD || state_reg == ST_WR) begin
					shift_reg <= {shift_reg[6:0], sda_sync[1]};
					bit_cnt   <= 4'(bit_cnt + 4'h1);
				end else if (state_reg == ST_RD) begin
					bit_cnt <= 4'(bit_cnt + 4'h1);
				end else if (state_reg == ST_RD_ACK) begin
					nack_reg <= sda_sync[1];
				end
			end else if (scl_fall) begin
				unique case (state_reg)
					ST_IDLE: begin
						sda_oe <= 1'b0;
					end
					ST_DEV: if (bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						if (shift_reg[7:1] == DEV_ADDR) begin
							rw_reg    <= shift_reg[0];
							sda_oe    <= 1'b1;
							state_reg <= ST_DEV_ACK;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
					ST_DEV_ACK: begin
						if (rw_reg) begin
							shift_reg <= {rd_data[6:0], 1'b0};
							sda_oe    <= !rd_data[7];
							state_reg <= ST_RD;
						end else begin
							sda_oe    <= 1'b0;
							state_reg <= ST_WORD;
						end
					end
					ST_WORD: if (bit_cnt == 4'h8) begin
						bit_cnt   <= 4'h0;
						ptr       <= shift_reg; // [R14]
						sda_oe    <= 1'b1;
						state_reg <= ST_WORD_ACK;
					end
					ST_WORD_ACK: begin
						sda_oe    <= 1'b0;
						state_reg <= ST_WR;
					end
					ST_WR: if (bit_cnt == 4'h8) begin
						bit_cnt   <= 4'h0;
						wr_en     <= 1'b1;
						wr_data   <= shift_reg;
						sda_oe    <= 1'b1;
						state_reg <= ST_WR_ACK;
					end
					ST_WR_ACK: begin
						sda_oe    <= 1'b0;
						ptr       <= ptr_step(ptr);
						state_reg <= ST_WR;
					end
					ST_RD: begin
						if (bit_cnt == 4'h8) begin
							bit_cnt   <= 4'h0;
							sda_oe    <= 1'b0;
							ptr       <= ptr_step(ptr); // [R14]
							state_reg <= ST_RD_ACK;
						end else begin
							sda_oe    <= !shift_reg[7];
							shift_reg <= {shift_reg[6:0], 1'b0};
						end
					end
					ST_RD_ACK: begin
						if (!nack_reg) begin
							shift_reg <= {rd_data[6:0], 1'b0};
							sda_oe    <= !rd_data[7];
							state_reg <= ST_RD;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				endcase
			end
		end
	end

endmodule // reg_serial_slave

`default_nettype wire

/* dv/rtc_tcdst_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module rtc_tcdst_checker #(
	parameter int ANALOG_TRIM_W  = 6,
	parameter int DIGITAL_TRIM_W = 3
) (
	input wire logic                      clk,
	input wire logic                      rst_b,
	input wire logic                      hour_tick,
	input wire logic                      comp_cycle_start,
	input wire logic [ANALOG_TRIM_W-1:0]  analog_freq_trim,
	input wire logic [DIGITAL_TRIM_W-1:0] digital_freq_trim,
	input wire logic                      dst_advance,
	input wire logic                      dst_retard,
	input wire logic                      daylight_forward_done,
	input wire logic                      sda_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Hour changes only follow a calendar hour tick
	a_adv_after_tick: assert property (dst_advance |-> $past(hour_tick))
		else $error("advance without hour tick");
	a_ret_after_tick: assert property (dst_retard |-> $past(hour_tick))
		else $error("retard without hour tick");
	a_adv_one_pulse: assert property (dst_advance |=> !dst_advance && !dst_retard)
		else $error("advance pulse too long");
	// Status flag follows the adjustments
	a_flag_rise_cause: assert property ($rose(daylight_forward_done) |-> $past(dst_advance))
		else $error("flag set without advance");
	a_ret_clears_flag: assert property (dst_retard |=> !daylight_forward_done)
		else $error("flag kept after retard");
	a_adv_flag_clear: assert property (dst_advance |-> !daylight_forward_done)
		else $error("advance while flag set");
	a_ret_flag_set: assert property (dst_retard |-> daylight_forward_done)
		else $error("retard while flag clear");
	// Trims move only with a compensation start
	a_trim_on_start: assert property (($changed(analog_freq_trim)
		|| $changed(digital_freq_trim)) |-> comp_cycle_start)
		else $error("trim changed without start");
	a_sda_pull_low: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
endmodule // rtc_tcdst_checker

`default_nettype wire

/* dv/i2c_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model
	import rtc_tcdst_pkg::*;
(
	input  wire logic clk,
	input  wire logic sda_line,
	output var logic  scl,
	output var logic  sda_drv
);
	logic nak;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
		nak = 1'b0;
	end
	// One bit: data set while SCL low, sampled at the end of SCL high, just before it falls
	task automatic bitx(input logic b, output logic r);
		repeat (8) @(negedge clk);
		sda_drv = b;
		repeat (8) @(negedge clk);
		scl = 1'b1;
		repeat (8) @(negedge clk);
		r = sda_line;
		scl = 1'b0;
	endtask
	task automatic start;
		sda_drv = 1'b1;
		repeat (8) @(negedge clk);
		scl = 1'b1;
		repeat (8) @(negedge clk);
		sda_drv = 1'b0;
		repeat (8) @(negedge clk);
		scl = 1'b0;
	endtask
	task automatic stop;
		repeat (8) @(negedge clk);
		sda_drv = 1'b0;
		repeat (8) @(negedge clk);
		scl = 1'b1;
		repeat (8) @(negedge clk);
		sda_drv = 1'b1;
	endtask
	// Byte out MSB first; a missing acknowledge is remembered
	task automatic tx(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		if (r !== 1'b0) nak = 1'b1;
	endtask
	task automatic rx(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(last, r);
	endtask
	// Slave byte, then one-byte word address
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		start();
		tx({DEV_ADDR_DEFAULT, 1'b0});
		tx(a);
		tx(d);
		stop();
	endtask
	// Random read of two consecutive bytes
	task automatic rd(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
		start();
		tx({DEV_ADDR_DEFAULT, 1'b0});
		tx(a);
		start();
		tx({DEV_ADDR_DEFAULT, 1'b1});
		rx(1'b0, d0);
		rx(1'b1, d1);
		stop();
	endtask
endmodule // i2c_host_model

`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import rtc_tcdst_pkg::*;
;
	localparam logic [7:0] FUSE_TO = 8'h3C;
	localparam logic [7:0] FUSE_CC = 8'hC3;
	localparam logic [4:0] FUSE_SL = 5'h16;
	logic       clk, rst_b, scl, sda_drv, sda_out, sda_oe, hour_tick, vdd_present, on_battery;
	logic       comp_cycle_start, dst_advance, dst_retard, daylight_forward_done;
	logic [9:0] temp_code;
	logic [5:0] corr_analog, analog_freq_trim;
	logic [2:0] corr_digital, digital_freq_trim, cal_weekday;
	logic [1:0] comp_batt_mode;
	logic [7:0] cal_month, cal_date, cal_hour, cal_month_len;
	int         bad_count, n_compared, n_start, n_adv, n_ret;
	wire logic  sda_line = sda_drv & ~sda_oe;

	always #50 clk = ~clk;
	// Pulse counters
	always @(posedge clk) begin
		if (comp_cycle_start === 1'b1) n_start++;
		if (dst_advance === 1'b1) n_adv++;
		if (dst_retard === 1'b1) n_ret++;
	end

	i2c_host_model u_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

	rtc_tempcomp_dst_control #(.CORR_PERIOD(100)) u_dut (
		.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .fuse_trim_offset(FUSE_TO),
		.fuse_curve_coeff(FUSE_CC), .fuse_slope_trim(FUSE_SL),
		.vdd_present(vdd_present), .on_battery(on_battery), .temp_code(temp_code),
		.corr_analog(corr_analog), .corr_digital(corr_digital), .hour_tick(hour_tick),
		.cal_month(cal_month), .cal_date(cal_date), .cal_hour(cal_hour),
		.cal_weekday(cal_weekday), .cal_month_len(cal_month_len),
		.comp_cycle_start(comp_cycle_start), .comp_batt_mode(comp_batt_mode),
		.analog_freq_trim(analog_freq_trim), .digital_freq_trim(digital_freq_trim),
		.dst_advance(dst_advance), .dst_retard(dst_retard),
		.daylight_forward_done(daylight_forward_done));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("mismatches %0d compares %0d", bad_count, n_compared);
		if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Read-only registers ignore writes and show factory values
	task automatic t_readonly;
		logic [7:0] d0, d1;
		u_host.wr(ADDR_TRIM_OFFSET, 8'h5A);
		u_host.wr(ADDR_CURVE_COEFF, 8'hA5);
		u_host.rd(ADDR_TRIM_OFFSET, d0, d1);
		check(d0, FUSE_TO);
		check(d1, FUSE_CC);
		u_host.rd(ADDR_CURVE_COEFF, d0, d1);
		check(d1, {3'h0, FUSE_SL});
		u_host.rd(8'h20, d0, d1);
		check(d0, 8'h00);
	endtask
	// Enable, periodic starts, trim loading, battery behaviour
	task automatic t_comp;
		logic [7:0] d0, d1;
		int s0;
		u_host.rd(ADDR_SLOPE_CTRL, d0, d1);
		corr_analog = 6'h2A;
		corr_digital = 3'h5;
		u_host.wr(ADDR_SLOPE_CTRL, {3'b111, d0[4:0]});
		check({2'h0, analog_freq_trim}, 8'h2A);
		check({5'h0, digital_freq_trim}, 8'h05);
		check({6'h0, comp_batt_mode}, 8'h03);
		corr_analog = 6'h15;
		s0 = n_start;
		repeat (250) @(negedge clk);
		check({7'h0, (n_start - s0) inside {2, 3}}, 8'h01);
		check({2'h0, analog_freq_trim}, 8'h2A);
		temp_code = 10'h156;
		repeat (150) @(negedge clk);
		check({2'h0, analog_freq_trim}, 8'h15);
		u_host.wr(ADDR_SLOPE_CTRL, 8'hDF);
		u_host.rd(ADDR_SLOPE_CTRL, d0, d1);
		check(d0, {3'b110, FUSE_SL});
		check({6'h0, comp_batt_mode}, 8'h02);
		vdd_present = 1'b0;
		on_battery = 1'b1;
		u_host.wr(ADDR_SLOPE_CTRL, 8'h00);
		s0 = n_start;
		u_host.wr(ADDR_SLOPE_CTRL, 8'h80);
		check(8'(n_start - s0), 8'h01);
		repeat (250) @(negedge clk);
		check(8'(n_start - s0), 8'h01);
		u_host.wr(ADDR_SLOPE_CTRL, 8'h00);
		vdd_present = 1'b1;
		on_battery = 1'b0;
	endtask
	// Calendar hour tick with given date fields
	task automatic tick(input logic [7:0] mo, dt, hr, ln, input logic [2:0] wd);
		cal_month = mo;
		cal_date = dt;
		cal_hour = hr;
		cal_month_len = ln;
		cal_weekday = wd;
		@(negedge clk);
		hour_tick = 1'b1;
		@(negedge clk);
		hour_tick = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	// Forward and reverse settings, last-week match, flag behaviour
	task automatic t_dst;
		logic [7:0] tbl [8] = '{8'h84, 8'h48, 8'h00, 8'h02, 8'h10, 8'h78, 8'h00, 8'h02};
		logic [7:0] d0, d1;
		int a0, r0;
		for (int i = 0; i < 8; i++) u_host.wr(ADDR_FWD_MONTH + 8'(i), tbl[i]);
		u_host.rd(ADDR_FWD_MONTH, d0, d1);
		check(d0, 8'h84);
		check(d1, 8'h48);
		a0 = n_adv;
		r0 = n_ret;
		tick(8'h04, 8'h03, 8'h01, 8'h30, 3'h0);
		check(8'(n_adv - a0), 8'h00);
		tick(8'h04, 8'h03, 8'h02, 8'h30, 3'h0);
		check(8'(n_adv - a0), 8'h01);
		check({7'h0, daylight_forward_done}, 8'h01);
		tick(8'h10, 8'h24, 8'h02, 8'h31, 3'h0);
		check(8'(n_ret - r0), 8'h00);
		tick(8'h10, 8'h27, 8'h02, 8'h31, 3'h0);
		check(8'(n_ret - r0), 8'h01);
		check({7'h0, daylight_forward_done}, 8'h00);
		tick(8'h04, 8'h03, 8'h02, 8'h30, 3'h0);
		check({7'h0, daylight_forward_done}, 8'h01);
		u_host.wr(ADDR_FWD_MONTH, 8'h04);
		check({7'h0, daylight_forward_done}, 8'h00);
		check({7'h0, u_host.nak}, 8'h00);
	endtask

	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		hour_tick = 1'b0;
		vdd_present = 1'b1;
		on_battery = 1'b0;
		temp_code = 10'h155;
		corr_analog = 6'h00;
		corr_digital = 3'h0;
		{cal_month, cal_date, cal_hour, cal_month_len} = 32'h0101_0031;
		cal_weekday = 3'h0;
		{bad_count, n_compared, n_start, n_adv, n_ret} = '0;
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		repeat (8) @(negedge clk);
		t_readonly();
		t_comp();
		t_dst();
		final_report();
	end
	// Hang guard
	initial begin
		#5_000_000;
		bad_count++;
		final_report();
	end
endmodule // tb_top

bind rtc_tempcomp_dst_control rtc_tcdst_checker #(
	.ANALOG_TRIM_W(ANALOG_TRIM_W), .DIGITAL_TRIM_W(DIGITAL_TRIM_W)) u_chk (
	.clk(clk), .rst_b(rst_b), .hour_tick(hour_tick), .comp_cycle_start(comp_cycle_start),
	.analog_freq_trim(analog_freq_trim), .digital_freq_trim(digital_freq_trim),
	.dst_advance(dst_advance), .dst_retard(dst_retard),
	.daylight_forward_done(daylight_forward_done), .sda_out(sda_out));

`default_nettype wire
